// ==== hw/vcc_chan.sv ====
// One comparator instance: input synchroniser, control and trim registers, output bit
`timescale 1ns/1ps
`default_nettype none
module vcc_chan
   import vcc_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_raw,
   input wire logic i_wr_ctl,
   input wire logic i_wr_trim,
   input wire logic [DATA_W-1:0] i_wdata,
   output var vcc_ctl_s o_ctl,
   output var vcc_trim_s o_trim,
   output var vcc_ana_s o_ana,
   output logic o_raw,
   output logic o_result,
   output logic o_change
);

   // Synchroniser chain and the accepted raw level
   logic sync1_r, sync2_r, sync3_r, raw_r, raw_nxt;
   // Stored control fields; the result bit lives apart
   vcc_ctl_s ctl_r, ctl_nxt;
   vcc_trim_s trim_r, trim_nxt;
   logic result_r, result_nxt;
   vcc_ana_s ana_r, ana_nxt;
   vcc_ctl_s wctl;
   vcc_trim_s wtrim;

   // Accept a new level only when the last two stages agree; stage one feeds stage two only
   always_comb begin
      raw_nxt = raw_r;
      if (sync2_r == sync3_r) begin
         raw_nxt = sync3_r;
      end
   end

   // Register the synchroniser
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         sync3_r <= 1'b0;
         raw_r <= 1'b0;
      end else begin
         sync1_r <= i_raw;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         raw_r <= raw_nxt;
      end
   end

   // Register writes and the polarity-adjusted output bit
   always_comb begin
      wctl = vcc_ctl_s'(i_wdata);
      wtrim = vcc_trim_s'(i_wdata);
      ctl_nxt = ctl_r;
      trim_nxt = trim_r;
      if (i_wr_ctl) begin
         // Only writable fields are taken; unused and read-only bits stay zero
         ctl_nxt.cmp_enable = wctl.cmp_enable;
         ctl_nxt.output_polarity = wctl.output_polarity;
         ctl_nxt.response_time_sel = wctl.response_time_sel;
      end
      if (i_wr_trim) begin
         trim_nxt.calibration_mode = wtrim.calibration_mode;
         trim_nxt.calibration_ref_sel = wtrim.calibration_ref_sel;
         trim_nxt.offset_trim = wtrim.offset_trim;
      end
      // Uses the new settings so a write takes effect on the same edge
      result_nxt = ctl_nxt.cmp_enable & (raw_nxt ^ ctl_nxt.output_polarity);
      ana_nxt.power_on = ctl_nxt.cmp_enable;
      ana_nxt.pullup_off = ctl_nxt.cmp_enable;
      ana_nxt.hyst_en = ~trim_nxt.calibration_mode;
      ana_nxt.response_time_sel = ctl_nxt.response_time_sel;
      ana_nxt.calibration_mode = trim_nxt.calibration_mode;
      // Reference select is passed on always; the core honours it only in calibration
      ana_nxt.calibration_ref_sel = trim_nxt.calibration_ref_sel;
      ana_nxt.offset_trim = trim_nxt.offset_trim;
   end

   // Register control state
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         ctl_r <= CTL_RST;
         trim_r <= TRIM_RST;
         result_r <= 1'b0;
         ana_r <= ANA_RST;
      end else begin
         ctl_r <= ctl_nxt;
         trim_r <= trim_nxt;
         result_r <= result_nxt;
         ana_r <= ana_nxt;
      end
   end

   // The control read image splices in the live output bit; trim and core images pass as stored
   always_comb begin
      o_ctl = ctl_r;
      o_ctl.compare_result = result_r;
   end
   assign o_trim = trim_r;
   assign o_ana = ana_r;
   assign o_raw = raw_r;
   assign o_result = result_r;
   // Any change of the adjusted bit, from the pins or from a setting
   assign o_change = result_nxt ^ result_r;

endmodule
`default_nettype wire

// ==== hw/vcc_pkg.sv ====
// Shared constants, register layouts and carrier types of the comparator control block
package vcc_pkg;

   // Instance count and bus widths
   localparam int NUM_CMP = 2;
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   localparam int TRIM_W = 5;
   localparam int RESP_W = 2;

   // Register word indices on the plain register port
   localparam logic [ADDR_W-1:0] ADDR_CTL0 = 3'h0;
   localparam logic [ADDR_W-1:0] ADDR_TRIM0 = 3'h1;
   localparam logic [ADDR_W-1:0] ADDR_CTL1 = 3'h2;
   localparam logic [ADDR_W-1:0] ADDR_TRIM1 = 3'h3;
   localparam logic [ADDR_W-1:0] ADDR_FLAGS = 3'h4;

   // Control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic rsv7;
      logic cmp_enable;
      logic output_polarity;
      logic compare_result;
      logic [RESP_W-1:0] response_time_sel;
      logic [1:0] rsv10;
   } vcc_ctl_s;

   // Offset trim register layout, bit 7 down to bit 0
   typedef struct packed {
      logic rsv7;
      logic calibration_mode;
      logic calibration_ref_sel;
      logic [TRIM_W-1:0] offset_trim;
   } vcc_trim_s;

   // Interrupt flag and enable register layout
   typedef struct packed {
      logic mf_enable;
      logic [2:0] rsv64;
      logic [NUM_CMP-1:0] int_enable;
      logic [NUM_CMP-1:0] int_flag;
   } vcc_flags_s;

   // Controls handed to one analog comparator core
   typedef struct packed {
      logic power_on;
      logic pullup_off;
      logic hyst_en;
      logic [RESP_W-1:0] response_time_sel;
      logic calibration_mode;
      logic calibration_ref_sel;
      logic [TRIM_W-1:0] offset_trim;
   } vcc_ana_s;

   // Reset images
   localparam vcc_ctl_s CTL_RST = 8'h00;
   localparam vcc_trim_s TRIM_RST = 8'h10;
   localparam vcc_flags_s FLAGS_RST = 8'h00;
   localparam vcc_ana_s ANA_RST = 12'h210;
   localparam logic [DATA_W-1:0] RDATA_IDLE = 8'h00;

endpackage

// ==== hw/vcc_top.sv ====
// Top of the dual comparator control block: register port, flags, wake and pin routing
// Register words on the plain port
// Word 0 is the control of instance 0, word 1 its trim
// Word 2 is the control of instance 1, word 3 its trim
// Word 4 holds the shared enable, request enables and flags
// Unmapped words read as zero and drop their writes
//
// Timing seen from the port
// A pin change reaches the output bit on the fourth edge
// The flag and the wake pulse rise on that same edge
// Read data stand only in the cycle after the strobe
// A setting write moves the output bit on its own edge
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module vcc_top
   import vcc_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [DATA_W-1:0] o_rdata,
   input wire logic [NUM_CMP-1:0] i_cmp_raw,
   input wire logic i_low_power,
   output var vcc_ana_s [NUM_CMP-1:0] o_ana,
   output logic [NUM_CMP-1:0] o_cmp_pin,
   output logic [NUM_CMP-1:0] o_int_req,
   output logic o_wake_req
);

   // Per-instance write strobes
   logic [NUM_CMP-1:0] wr_ctl;
   logic [NUM_CMP-1:0] wr_trim;
   // Write strobe of the flag register
   logic wr_flags;
   // Read images from each instance
   vcc_ctl_s [NUM_CMP-1:0] ctl_img;
   vcc_trim_s [NUM_CMP-1:0] trim_img;
   // Synchronised raw level, adjusted bit and its change pulse
   logic [NUM_CMP-1:0] raw_lvl;
   logic [NUM_CMP-1:0] result;
   logic [NUM_CMP-1:0] change;
   logic [NUM_CMP-1:0] enabled;
   // Flag register and wake pulse
   vcc_flags_s flags_r, flags_nxt;
   logic wake_r, wake_nxt;
   // Read data, held for one cycle only
   logic [DATA_W-1:0] rdata_r, rdata_nxt;

   // Write address decode
   // Both strobes at once are illegal, so write and read decodes stay apart
   always_comb begin
      wr_ctl = '0;
      wr_trim = '0;
      wr_flags = 1'b0;
      if (!i_wr) begin
         // No write this cycle
         wr_flags = 1'b0;
      end else if (i_addr == ADDR_CTL0) begin
         wr_ctl[0] = 1'b1;
      end else if (i_addr == ADDR_TRIM0) begin
         wr_trim[0] = 1'b1;
      end else if (i_addr == ADDR_CTL1) begin
         wr_ctl[1] = 1'b1;
      end else if (i_addr == ADDR_TRIM1) begin
         wr_trim[1] = 1'b1;
      end else if (i_addr == ADDR_FLAGS) begin
         wr_flags = 1'b1;
      end
      // Unmapped writes fall through and are dropped
   end

   // Two identical instances share one layout
   for (genvar k = 0; k < NUM_CMP; k++) begin : g_cmp
      vcc_chan u_chan (
         .i_mclk(i_mclk),
         .i_rst(i_rst),
         .i_raw(i_cmp_raw[k]),
         .i_wr_ctl(wr_ctl[k]),
         .i_wr_trim(wr_trim[k]),
         .i_wdata(i_wdata),
         .o_ctl(ctl_img[k]),
         .o_trim(trim_img[k]),
         .o_ana(o_ana[k]),
         .o_raw(raw_lvl[k]),
         .o_result(result[k]),
         .o_change(change[k])
      );
      // Enable as stored, so the wake gate sees the setting before a write
      assign enabled[k] = ctl_img[k].cmp_enable;
   end

   // Flags and wake; nothing here looks at low power except the wake, so the
   // instances keep comparing in sleep and idle
   always_comb begin
      flags_nxt = flags_r;
      if (wr_flags) begin
         // Writing 1 sets a flag, writing 0 clears it
         flags_nxt = vcc_flags_s'(i_wdata);
         flags_nxt.rsv64 = '0;
      end
      // Hardware set beats a clearing write in the same cycle
      flags_nxt.int_flag = flags_nxt.int_flag | change;
      // Low power comes from this clock's own logic and needs no synchroniser
      // Only a flag going high from low wakes; a preset flag suppresses it
      wake_nxt = i_low_power & |(change & enabled & ~flags_r.int_flag);
   end

   // Register flags and wake
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         flags_r <= FLAGS_RST;
         wake_r <= 1'b0;
      end else begin
         flags_r <= flags_nxt;
         wake_r <= wake_nxt;
      end
   end

   // Read mux; data stand only in the cycle after the strobe
   always_comb begin
      rdata_nxt = RDATA_IDLE;
      if (!i_rd) begin
         rdata_nxt = RDATA_IDLE;
      end else if (i_addr == ADDR_CTL0) begin
         rdata_nxt = ctl_img[0];
      end else if (i_addr == ADDR_TRIM0) begin
         rdata_nxt = trim_img[0];
      end else if (i_addr == ADDR_CTL1) begin
         rdata_nxt = ctl_img[1];
      end else if (i_addr == ADDR_TRIM1) begin
         rdata_nxt = trim_img[1];
      end else if (i_addr == ADDR_FLAGS) begin
         // Reserved flag bits are kept zero at the write, so no masking here
         rdata_nxt = flags_r;
      end
      // Unmapped reads answer zero
   end

   // Register read data
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         rdata_r <= RDATA_IDLE;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // Outputs
   assign o_rdata = rdata_r;
   // Pin sharing itself is outside; this is the bit to route
   assign o_cmp_pin = result;
   // Request gated by per-instance and multi-function enables
   assign o_int_req = flags_r.int_flag & flags_r.int_enable & {NUM_CMP{flags_r.mf_enable}};
   // One-cycle pulse; the power controller must latch it
   assign o_wake_req = wake_r;

   // Checks on the block's own behaviour
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_rst);

   for (genvar k = 0; k < NUM_CMP; k++) begin : g_chk
      // Pin held still for four samples
      sequence s_pin_steady;
         $stable(i_cmp_raw[k]) [*4];
      endsequence

      // A write to this control word
      sequence s_ctl_write;
         i_wr && (i_addr == (k == 0 ? ADDR_CTL0 : ADDR_CTL1));
      endsequence

      // A read of this control word
      sequence s_ctl_read;
         i_rd && (i_addr == (k == 0 ? ADDR_CTL0 : ADDR_CTL1));
      endsequence

      // A read of this trim word
      sequence s_trim_read;
         i_rd && (i_addr == (k == 0 ? ADDR_TRIM0 : ADDR_TRIM1));
      endsequence

      // A write to the flag word
      sequence s_flag_write;
         i_wr && (i_addr == ADDR_FLAGS);
      endsequence

      a_pullup_disconnect: assert property (o_ana[k].pullup_off == enabled[k])
         else $error("pull-up control does not follow enable");

      a_hyst_mode: assert property (o_ana[k].hyst_en != trim_img[k].calibration_mode)
         else $error("hysteresis not opposite to calibration mode");

      a_enable_write: assert property (s_ctl_write |=> enabled[k] == $past(i_wdata[6]))
         else $error("enable bit did not take written value");

      a_off_low: assert property (!enabled[k] |-> !result[k])
         else $error("output bit high while disabled");

      a_pol_result: assert property (s_pin_steady ##0 enabled[k] && $stable(ctl_img[k])
         |-> result[k] == (i_cmp_raw[k] ^ ctl_img[k].output_polarity))
         else $error("output bit not polarity adjusted pin level");

      a_resp_drive: assert property (o_ana[k].response_time_sel == ctl_img[k].response_time_sel)
         else $error("response time not driven to core");

      a_unimpl_zero: assert property (s_ctl_read |=> o_rdata[7] == 1'b0 && o_rdata[1:0] == 2'b00)
         else $error("unimplemented control bits read nonzero");

      a_trim_drive: assert property (o_ana[k].offset_trim == trim_img[k].offset_trim
         && o_ana[k].calibration_mode == trim_img[k].calibration_mode)
         else $error("trim or mode not driven to core");

      a_sync_settle: assert property (s_pin_steady |-> raw_lvl[k] == i_cmp_raw[k])
         else $error("synchronised level missing after settle");

      a_flag_set: assert property (change[k] |=> flags_r.int_flag[k])
         else $error("output change did not set flag");

      a_flag_sticky: assert property (flags_r.int_flag[k] && !wr_flags |=> flags_r.int_flag[k])
         else $error("flag dropped without software clear");

      a_wake_cause: assert property (i_low_power && change[k] && enabled[k] && !flags_r.int_flag[k]
         |=> o_wake_req)
         else $error("no wake on change in low power");

      // Readback and routing of this instance
      a_ctl_readback: assert property (s_ctl_read |=> o_rdata == $past(ctl_img[k]))
         else $error("control word read back wrong");

      a_trim_readback: assert property (s_trim_read |=> o_rdata == $past(trim_img[k]))
         else $error("trim word read back wrong");

      a_trim_unimpl: assert property (s_trim_read |=> o_rdata[7] == 1'b0)
         else $error("unimplemented trim bit reads nonzero");

      a_pin_route: assert property (o_cmp_pin[k] == ctl_img[k].compare_result)
         else $error("pin bit differs from output bit");

      a_power_drive: assert property (o_ana[k].power_on == enabled[k])
         else $error("core power does not follow enable");

      a_ref_drive: assert property (o_ana[k].calibration_ref_sel == trim_img[k].calibration_ref_sel)
         else $error("reference select not driven to core");

      // Software access to this flag
      a_flag_wset: assert property (s_flag_write ##0 i_wdata[k] |=> flags_r.int_flag[k])
         else $error("written one did not set flag");

      a_flag_wclear: assert property (s_flag_write ##0 (!i_wdata[k] && !change[k])
         |=> !flags_r.int_flag[k])
         else $error("written zero did not clear flag");

      a_irq_source: assert property (o_int_req[k] |-> flags_r.int_flag[k] && flags_r.int_enable[k])
         else $error("request without flag and enable");
   end

   a_wake_suppress: assert property (o_wake_req |-> $past(i_low_power)
      && $past(|(change & ~flags_r.int_flag)))
      else $error("wake without unflagged change in low power");

   a_rdata_one: assert property (!$past(i_rd) |-> o_rdata == RDATA_IDLE)
      else $error("read data outside answer cycle");

   a_irq_gate: assert property (o_int_req != '0 |-> flags_r.mf_enable)
      else $error("request without multi-function enable");

   // Wake comes only from an enabled instance
   a_wake_enabled: assert property (o_wake_req |-> $past(|(change & enabled)))
      else $error("wake without change of an enabled instance");

   // The flag word reads back as stored
   a_flags_readback: assert property (i_rd && i_addr == ADDR_FLAGS |=> o_rdata == $past(flags_r))
      else $error("flag word read back wrong");

endmodule
`default_nettype wire

// ==== verification/vcc_ana_model.sv ====
// Behavioural model of one analog comparator core facing the control block
`timescale 1ns/1ps
`default_nettype none
module vcc_ana_model
   import vcc_pkg::*;
#(
   parameter int CAL_POINT = 13 // Hidden offset point; trims above it read high
)
(
   input wire logic i_mclk,
   input wire vcc_ana_s i_ana,
   input wire logic [15:0] i_pos_mv,
   input wire logic [15:0] i_neg_mv,
   output logic o_raw
);
   logic wander_r = 1'b0; // Output of an unpowered core is not trustworthy
   // Flip every cycle so a forced-low output bit is really exercised
   always @(posedge i_mclk) begin
      wander_r <= ~wander_r;
   end
   // Raw comparison; the control block supplies polarity and gating
   always_comb begin
      if (!i_ana.power_on) begin
         o_raw = wander_r;
      end else if (i_ana.calibration_mode) begin
         // Both inputs see the reference, so only the trim decides
         o_raw = (int'(i_ana.offset_trim) > CAL_POINT);
      end else begin
         o_raw = (i_pos_mv > i_neg_mv);
      end
   end
endmodule
`default_nettype wire

// ==== verification/vcc_top_tb_top.sv ====
// Self-checking bench for the dual comparator control block
`timescale 1ns/1ps
`default_nettype none
module vcc_top_tb_top
   import vcc_pkg::*;
;
   localparam int CAL_POINT = 13; // Offset point of the analog model
   logic i_mclk;
   logic i_rst;
   logic [ADDR_W-1:0] i_addr;
   logic [DATA_W-1:0] i_wdata;
   logic i_wr;
   logic i_rd;
   logic [DATA_W-1:0] o_rdata;
   wire logic [NUM_CMP-1:0] i_cmp_raw;
   logic i_low_power;
   vcc_ana_s [NUM_CMP-1:0] o_ana;
   logic [NUM_CMP-1:0] o_cmp_pin;
   logic [NUM_CMP-1:0] o_int_req;
   logic o_wake_req;
   logic [15:0] pos [NUM_CMP]; // Analog input levels per instance
   logic [15:0] neg [NUM_CMP];
   int n_mismatch = 0;
   int cmp_count = 0;
   int wake_cnt = 0; // Wake pulses seen
   int cyc = 0; // Cycle count for the hang guard
   logic [7:0] d;
   logic [7:0] first;
   int up;
   int down;

   vcc_top DUT (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .i_cmp_raw(i_cmp_raw), .i_low_power(i_low_power),
      .o_ana(o_ana), .o_cmp_pin(o_cmp_pin), .o_int_req(o_int_req), .o_wake_req(o_wake_req));

   for (genvar g = 0; g < NUM_CMP; g++) begin : g_ana
      vcc_ana_model #(.CAL_POINT(CAL_POINT)) u_model (.i_mclk(i_mclk), .i_ana(o_ana[g]),
         .i_pos_mv(pos[g]), .i_neg_mv(neg[g]), .o_raw(i_cmp_raw[g]));
   end

   // 25 MHz clock
   initial begin
      i_mclk = 1'b0;
      forever #20 i_mclk = ~i_mclk;
   end

   // Hang guard and wake pulse counter
   always @(posedge i_mclk) begin
      cyc <= cyc + 1;
      if (o_wake_req === 1'b1) begin
         wake_cnt <= wake_cnt + 1;
      end
      if (cyc == 5000) begin
         n_mismatch++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One-cycle write strobe, taken at the next edge
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
      @(posedge i_mclk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= v;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
      @(posedge i_mclk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      @(negedge i_mclk);
      v = o_rdata;
   endtask

   task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
      logic [7:0] v;
      rd_reg(a, v);
      chk({4'h0, v}, {4'h0, exp});
   endtask

   // Set analog levels, then allow the synchroniser latency to pass
   task automatic drive(input int ch, input logic [15:0] p, input logic [15:0] n);
      @(posedge i_mclk);
      pos[ch] <= p;
      neg[ch] <= n;
      repeat (6) @(posedge i_mclk);
   endtask

   function automatic vcc_ana_s mk_ana(input logic en, input logic [1:0] rt, input logic [7:0] t);
      return {en, en, ~t[6], rt, t[6], t[5], t[4:0]};
   endfunction

   // Trim sweep from a start value until the output bit toggles
   task automatic sweep(input int start, input int step, output int found);
      logic [7:0] v;
      wr_reg(ADDR_TRIM1, 8'(8'h60 | start));
      repeat (6) @(posedge i_mclk);
      rd_reg(ADDR_CTL1, first);
      found = start;
      do begin
         found += step;
         wr_reg(ADDR_TRIM1, 8'(8'h60 | found));
         repeat (6) @(posedge i_mclk);
         rd_reg(ADDR_CTL1, v);
      end while (v[4] === first[4] && found > 0 && found < 31);
   endtask

   initial begin
      i_rst = 1'b1;
      i_addr = '0;
      i_wdata = '0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_low_power = 1'b0;
      pos = '{16'd100, 16'd100};
      neg = '{16'd200, 16'd200};
      repeat (6) @(posedge i_mclk);
      i_rst <= 1'b0;
      // Reset images, including one unmapped word
      for (int a = 0; a < 6; a++) begin
         rd_chk(3'(a), (a == 1 || a == 3) ? 8'h10 : 8'h00);
      end
      chk(o_ana[0], ANA_RST);
      $display("test reset done");
      // Both instances: settings, polarity, response codes, trim fields
      for (int ch = 0; ch < NUM_CMP; ch++) begin
         wr_reg(3'(2 * ch), 8'hFF);
         repeat (6) @(posedge i_mclk);
         rd_chk(3'(2 * ch), 8'h7C);
         chk(12'(o_cmp_pin[ch]), 12'h001);
         chk(o_ana[ch], mk_ana(1'b1, 2'h3, 8'h10));
         for (int c = 0; c < 4; c++) begin
            wr_reg(3'(2 * ch), 8'(8'h40 | (c << 2)));
            rd_chk(3'(2 * ch), 8'(8'h40 | (c << 2)));
            chk(o_ana[ch], mk_ana(1'b1, 2'(c), 8'h10));
         end
         wr_reg(3'(2 * ch + 1), 8'hFF);
         rd_chk(3'(2 * ch + 1), 8'h7F);
         chk(o_ana[ch], mk_ana(1'b1, 2'h3, 8'h7F));
         wr_reg(3'(2 * ch + 1), 8'h10);
      end
      repeat (6) @(posedge i_mclk); // Let the last calibration exit reach the flags
      $display("test settings done");
      // Flag on both output edges, sticky, gated request
      wr_reg(ADDR_FLAGS, 8'h00);
      drive(0, 16'd300, 16'd200);
      rd_chk(ADDR_CTL0, 8'h5C);
      rd_chk(ADDR_FLAGS, 8'h01);
      chk(12'(o_int_req), 12'h000);
      wr_reg(ADDR_FLAGS, 8'h05);
      @(negedge i_mclk);
      chk(12'(o_int_req), 12'h000);
      wr_reg(ADDR_FLAGS, 8'h8F);
      @(negedge i_mclk);
      chk(12'(o_int_req), 12'h003);
      wr_reg(ADDR_FLAGS, 8'h84);
      drive(0, 16'd100, 16'd200);
      rd_chk(ADDR_FLAGS, 8'h85);
      $display("test flags done");
      // Disabled instance holds its output low while the core wanders
      drive(0, 16'd300, 16'd200);
      wr_reg(ADDR_CTL0, 8'h0C);
      wr_reg(ADDR_FLAGS, 8'h00);
      for (int i = 0; i < 8; i++) begin
         @(negedge i_mclk);
         chk(12'(o_cmp_pin[0]), 12'h000);
      end
      rd_chk(ADDR_CTL0, 8'h0C);
      rd_chk(ADDR_FLAGS, 8'h00);
      chk(o_ana[0], mk_ana(1'b0, 2'h3, 8'h10));
      $display("test disable done");
      // Wake from low power, then suppressed by a preset flag
      wr_reg(ADDR_CTL0, 8'h4C);
      drive(0, 16'd300, 16'd200);
      wr_reg(ADDR_FLAGS, 8'h00);
      i_low_power <= 1'b1;
      wake_cnt = 0;
      drive(0, 16'd100, 16'd200);
      chk(12'(wake_cnt), 12'h001);
      rd_chk(ADDR_FLAGS, 8'h01);
      wr_reg(ADDR_FLAGS, 8'h01);
      drive(0, 16'd300, 16'd200);
      chk(12'(wake_cnt), 12'h001);
      rd_chk(ADDR_CTL0, 8'h5C);
      i_low_power <= 1'b0;
      $display("test wake done");
      // Offset calibration of instance 1; pins already routed to the core
      sweep(0, 1, up);
      sweep(31, -1, down);
      chk(12'(up), 12'(CAL_POINT + 1));
      chk(12'(down), 12'(CAL_POINT));
      wr_reg(ADDR_TRIM1, 8'((up + down) / 2));
      rd_chk(ADDR_TRIM1, 8'(CAL_POINT));
      chk(o_ana[1], mk_ana(1'b1, 2'h3, 8'(CAL_POINT)));
      $display("test calibration done");
      end_sim();
   end
endmodule
`default_nettype wire
